// [rtl/cptm_pkg.sv]
package cptm_pkg;

  // register byte offsets on the avalon slave, one aligned word each
  localparam logic [4:0] REG_RUN_CLOCK_CONTROL  = 5'h00;
  localparam logic [4:0] REG_MODE_OUTPUT_CONTROL = 5'h04;
  localparam logic [4:0] REG_COUNT_LOW_BYTE     = 5'h08;
  localparam logic [4:0] REG_COUNT_HIGH_BYTE    = 5'h0c;
  localparam logic [4:0] REG_COMPARE_A_LOW_BYTE  = 5'h10;
  localparam logic [4:0] REG_COMPARE_A_HIGH_BYTE = 5'h14;

  // run_clock_control fields
  localparam int RCC_PAUSE_BIT = 7;
  localparam int RCC_CKS_MSB   = 6;
  localparam int RCC_CKS_LSB   = 4;
  localparam int RCC_RUN_BIT   = 3;
  localparam int RCC_RP_MSB    = 2;
  localparam int RCC_RP_LSB    = 0;

  // mode_output_control fields
  localparam int MOC_MODE_MSB = 7;
  localparam int MOC_MODE_LSB = 6;
  localparam int MOC_IO_MSB   = 5;
  localparam int MOC_IO_LSB   = 4;
  localparam int MOC_OC_BIT   = 3;
  localparam int MOC_POL_BIT  = 2;
  localparam int MOC_DPX_BIT  = 1;
  localparam int MOC_CLR_BIT  = 0;

  localparam logic [7:0] RCC_RESET = 8'h00;
  localparam logic [7:0] MOC_RESET = 8'h00;

  // operating modes
  localparam logic [1:0] MODE_CMP   = 2'h0;
  localparam logic [1:0] MODE_PWM   = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;

  // pin actions
  localparam logic [1:0] IO_00 = 2'h0;
  localparam logic [1:0] IO_01 = 2'h1;
  localparam logic [1:0] IO_10 = 2'h2;
  localparam logic [1:0] IO_11 = 2'h3;

  // clock source codes
  localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CKS_SYS      = 3'h1;
  localparam logic [2:0] CKS_H_DIV16  = 3'h2;
  localparam logic [2:0] CKS_H_DIV64  = 3'h3;
  localparam logic [2:0] CKS_SUB_A    = 3'h4;
  localparam logic [2:0] CKS_SUB_B    = 3'h5;
  localparam logic [2:0] CKS_EXT_RISE = 3'h6;
  localparam logic [2:0] CKS_EXT_FALL = 3'h7;

  localparam logic [5:0]  DIV4_MASK   = 6'h03;
  localparam logic [5:0]  DIV16_MASK  = 6'h0f;
  localparam logic [5:0]  DIV64_MASK  = 6'h3f;
  localparam logic [9:0]  CNT_MAX     = 10'h3ff;
  localparam logic [10:0] FULL_PERIOD = 11'h400;

  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } cptm_bus_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } cptm_bus_rsp_s;

  typedef struct packed {
    logic [7:0]  run_clock_control;
    logic [7:0]  mode_output_control;
    logic [9:0]  count;
    logic [9:0]  compare_a_value;
    logic [7:0]  count_buf;
    logic [7:0]  compare_a_buf;
    logic        run_prev;
    logic        ext_prev;
    logic        sub_prev;
    logic [5:0]  prescale;
    logic        pin;
    logic        out;
    logic        out_n;
    logic        compare_a_flag;
    logic        period_compare_flag;
    logic        waitrequest;
    logic [31:0] readdata;
  } cptm_state_s;

endpackage : cptm_pkg

// [rtl/cptm_top.sv]
// Contract
// - counter advances only while run_enable is 1; clearing it holds the count
// - run_enable rising clears the 10-bit counter to zero
// - run_enable rising returns pin to output_initial_level in compare and pwm modes
// - period bits compare with counter bits 9..7, period code times 128 clocks
// - period code zero lets the counter run to 3ff and overflow
// - operating_mode_field: 00 compare, 01 undefined, 10 pwm, 11 timer
// - compare mode pin action on A match: none, low, high, toggle
// - pwm pin action: inactive, active, pwm waveform, undefined
// - initial level bit: compare pre-match level, pwm active polarity
// - output_invert inverts the pin, ignored in timer mode
// - swap bit: 0 period bits set period, A sets duty; 1 reversed
// - outside pwm mode, clear source 1 clears on A match, 0 on period match or overflow
// - counter readable as low byte and high byte bits 9..8, rest zero
// - compare A value held as read/write byte pair, high byte two bits
// - compare mode with clear source 0 raises both flags on their matches
// - outside pwm mode, clear source 1 never raises the period compare flag
// - compare A zero with clear source 1 overflows at 3ff, no A flag
// - in compare mode only an A match or a run_enable rise changes the pin
// - a match requesting the level already present shows no pin change
// - clock source field selects system, divided, sub or external edge clock
// - pause bit freezes the counter, clearing it resumes from that value
// - inverted pin is always the inverse of the primary pin
// - low bytes move through a buffer only on high byte accesses
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

module cptm_top
  import cptm_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire cptm_bus_req_s bus_req,
  output cptm_bus_rsp_s      bus_rsp,
  input  wire logic          external_count_input,
  input  wire logic          sub_clock,
  output logic               timer_output_pin,
  output logic               timer_output_inverted_pin,
  output logic               compare_a_flag,
  output logic               period_compare_flag
);

  cptm_state_s s_q;
  cptm_state_s s_d;

  logic        run;
  logic        run_rise;
  logic        pause;
  logic        tick;
  logic        pwm_mode;
  logic        cmp_mode;
  logic        timer_mode;
  logic [2:0]  period_bits;
  logic [9:0]  count_inc;
  logic        overflow;
  logic        period_match;
  logic        a_match;
  logic        clear_on_a;
  logic [10:0] duty;
  logic        pwm_active;
  logic        oc;
  logic        step;
  logic [1:0]  pin_act;
  logic        clr_bit;

  // level requested by a compare-mode pin action
  function automatic logic cmp_action(input logic [1:0] act, input logic cur);
    case (act)
      IO_01:   cmp_action = 1'b0;
      IO_10:   cmp_action = 1'b1;
      IO_11:   cmp_action = ~cur;
      default: cmp_action = cur;
    endcase
  endfunction : cmp_action

  always_comb begin
    s_d        = s_q;
    run        = s_q.run_clock_control[RCC_RUN_BIT];
    pause      = s_q.run_clock_control[RCC_PAUSE_BIT];
    period_bits = s_q.run_clock_control[RCC_RP_MSB:RCC_RP_LSB];
    run_rise   = run & ~s_q.run_prev;
    oc         = s_q.mode_output_control[MOC_OC_BIT];
    // 01 is undefined; it behaves as compare mode but an A match leaves the pin as it is
    pwm_mode   = s_q.mode_output_control[MOC_MODE_MSB:MOC_MODE_LSB] == MODE_PWM;
    timer_mode = s_q.mode_output_control[MOC_MODE_MSB:MOC_MODE_LSB] == MODE_TIMER;
    cmp_mode   = s_q.mode_output_control[MOC_MODE_MSB:MOC_MODE_LSB] == MODE_CMP;
    pin_act    = s_q.mode_output_control[MOC_IO_MSB:MOC_IO_LSB];
    clr_bit    = s_q.mode_output_control[MOC_CLR_BIT];

    // free-running prescaler; fH is taken equal to the core clock
    s_d.prescale = s_q.prescale + 6'h01;
    s_d.ext_prev = external_count_input;
    s_d.sub_prev = sub_clock;
    case (s_q.run_clock_control[RCC_CKS_MSB:RCC_CKS_LSB])
      CKS_SYS_DIV4: tick = (s_q.prescale & DIV4_MASK) == DIV4_MASK;
      CKS_SYS:      tick = 1'b1;
      CKS_H_DIV16:  tick = (s_q.prescale & DIV16_MASK) == DIV16_MASK;
      CKS_H_DIV64:  tick = (s_q.prescale & DIV64_MASK) == DIV64_MASK;
      CKS_SUB_A,
      CKS_SUB_B:    tick = sub_clock & ~s_q.sub_prev;
      CKS_EXT_RISE: tick = external_count_input & ~s_q.ext_prev;
      CKS_EXT_FALL: tick = ~external_count_input & s_q.ext_prev;
      default:      tick = 1'b0;
    endcase

    // a counting edge; shared by the checks below
    step = run & ~pause & tick & ~run_rise;

    // matches are judged on the value the counter is about to reach
    count_inc    = s_q.count + 10'h001;
    overflow     = s_q.count == CNT_MAX;
    period_match = (period_bits == 3'h0) ? overflow :
                   (count_inc[9:7] == period_bits) && (count_inc[6:0] == 7'h00);
    a_match      = (s_q.compare_a_value != 10'h000) && (count_inc == s_q.compare_a_value);
    clear_on_a   = pwm_mode ? s_q.mode_output_control[MOC_DPX_BIT]
                            : s_q.mode_output_control[MOC_CLR_BIT];

    // pwm duty: compare A, or when swapped period code times 128, with code zero giving 1024
    if (s_q.mode_output_control[MOC_DPX_BIT]) begin
      duty = (period_bits == 3'h0) ? FULL_PERIOD : {1'b0, period_bits, 7'h00};
    end else begin
      duty = {1'b0, s_q.compare_a_value};
    end
    pwm_active = {1'b0, s_q.count} < duty;

    // flags are single-cycle pulses
    s_d.compare_a_flag      = 1'b0;
    s_d.period_compare_flag = 1'b0;
    s_d.run_prev            = run;

    if (run_rise) begin
      s_d.count = 10'h000;
      if (!timer_mode) begin
        s_d.pin = oc;
      end
    end else if (run && !pause && tick) begin
      // overflow wraps to zero on its own, so only match clears need forcing
      s_d.count = (clear_on_a ? a_match : period_match) ? 10'h000 : count_inc;
      s_d.compare_a_flag      = a_match;
      s_d.period_compare_flag = period_match &&
                                (pwm_mode || !s_q.mode_output_control[MOC_CLR_BIT]);
      if (cmp_mode && a_match) begin
        // forcing the present level leaves the pin as it is
        s_d.pin = cmp_action(s_q.mode_output_control[MOC_IO_MSB:MOC_IO_LSB], s_q.pin);
      end
    end

    // pwm waveform follows the count while running; stays put when stopped
    if (pwm_mode && run && !run_rise) begin
      case (s_q.mode_output_control[MOC_IO_MSB:MOC_IO_LSB])
        IO_00:   s_d.pin = ~oc;
        IO_01:   s_d.pin = oc;
        IO_10:   s_d.pin = pwm_active ? oc : ~oc;
        default: s_d.pin = s_q.pin;
      endcase
    end

    s_d.out   = s_d.pin ^ (s_q.mode_output_control[MOC_POL_BIT] & ~timer_mode);
    s_d.out_n = ~s_d.out;

    // avalon slave: one wait cycle, then answer with waitrequest low
    if (!s_q.waitrequest) begin
      s_d.waitrequest = 1'b1;
    end else if (bus_req.read || bus_req.write) begin
      s_d.waitrequest = 1'b0;
      if (bus_req.read) begin
        case (bus_req.address)
          REG_RUN_CLOCK_CONTROL:   s_d.readdata = {24'h000000, s_q.run_clock_control};
          REG_MODE_OUTPUT_CONTROL: s_d.readdata = {24'h000000, s_q.mode_output_control};
          REG_COUNT_LOW_BYTE:      s_d.readdata = {24'h000000, s_q.count_buf};
          REG_COUNT_HIGH_BYTE: begin
            s_d.readdata  = {30'h00000000, s_q.count[9:8]};
            s_d.count_buf = s_q.count[7:0];
          end
          REG_COMPARE_A_LOW_BYTE:  s_d.readdata = {24'h000000, s_q.compare_a_buf};
          REG_COMPARE_A_HIGH_BYTE: begin
            s_d.readdata      = {30'h00000000, s_q.compare_a_value[9:8]};
            s_d.compare_a_buf = s_q.compare_a_value[7:0];
          end
          default: s_d.readdata = 32'h00000000;
        endcase
      end else if (bus_req.byteenable[0]) begin
        // counter registers are read only; writes there are dropped
        case (bus_req.address)
          REG_RUN_CLOCK_CONTROL:   s_d.run_clock_control = bus_req.writedata[7:0];
          REG_MODE_OUTPUT_CONTROL: s_d.mode_output_control = bus_req.writedata[7:0];
          REG_COMPARE_A_LOW_BYTE:  s_d.compare_a_buf = bus_req.writedata[7:0];
          REG_COMPARE_A_HIGH_BYTE:
            s_d.compare_a_value = {bus_req.writedata[1:0], s_q.compare_a_buf};
          default: s_d.readdata = s_q.readdata;
        endcase
      end
    end
  end

  // the whole block state in one register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q                     <= '0;
      s_q.run_clock_control   <= RCC_RESET;
      s_q.mode_output_control <= MOC_RESET;
      s_q.out_n               <= 1'b1;
      s_q.waitrequest         <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rsp.readdata          = s_q.readdata;
  assign bus_rsp.waitrequest       = s_q.waitrequest;
  assign timer_output_pin          = s_q.out;
  assign timer_output_inverted_pin = s_q.out_n;
  assign compare_a_flag            = s_q.compare_a_flag;
  assign period_compare_flag       = s_q.period_compare_flag;

  // checks on the block's own behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_run_rise_clear: assert property (run_rise |=> s_q.count == 10'h000)
    else $error("counter not cleared on run enable rise");

  a_off_holds_count: assert property (!run && s_q.run_prev == 1'b0 |=> $stable(s_q.count))
    else $error("counter moved while run enable low");

  a_pause_freezes: assert property (run && pause && !run_rise |=> $stable(s_q.count))
    else $error("counter moved while paused");

  a_inverted_pin: assert property (timer_output_inverted_pin == ~timer_output_pin)
    else $error("inverted pin not complement of pin");

  a_pflag_blocked: assert property (
      period_compare_flag |-> $past(pwm_mode) || !$past(s_q.mode_output_control[MOC_CLR_BIT]))
    else $error("period flag raised with clear source on compare A");

  a_initial_level: assert property (run_rise && cmp_mode |=> timer_output_pin ==
      ($past(oc) ^ $past(s_q.mode_output_control[MOC_POL_BIT])))
    else $error("pin not at initial level after run enable rise");

  a_period_clear: assert property (period_compare_flag && !$past(pwm_mode) &&
      $past(period_bits) != 3'h0 |-> s_q.count == 10'h000 &&
      $past(s_q.count) + 10'h001 == {$past(period_bits), 7'h00})
    else $error("period match not at code times 128");

  a_full_overflow: assert property (period_compare_flag && $past(period_bits) == 3'h0
      |-> $past(s_q.count) == CNT_MAX)
    else $error("period flag with code zero not at overflow");

  a_zero_a_noflag: assert property ($past(s_q.compare_a_value) == 10'h000 |-> !compare_a_flag)
    else $error("compare A flag with zero compare value");

  a_pin_only_a: assert property ($past(cmp_mode && run && !run_rise) && !compare_a_flag &&
      $stable(s_q.mode_output_control) |-> $stable(timer_output_pin))
    else $error("pin changed without compare A match");

  a_bus_answer: assert property ((bus_req.read || bus_req.write) && s_q.waitrequest
      |=> !s_q.waitrequest ##1 s_q.waitrequest)
    else $error("bus request not answered in one cycle");

  // compare mode: the pin action decides the level after each A match
  a_cmp_high: assert property (
      compare_a_flag && $past(cmp_mode) && $past(pin_act) == IO_10 |-> s_q.pin)
    else $error("pin not high after compare A match");

  a_cmp_low: assert property (
      compare_a_flag && $past(cmp_mode) && $past(pin_act) == IO_01 |-> !s_q.pin)
    else $error("pin not low after compare A match");

  a_cmp_toggle: assert property (
      compare_a_flag && $past(cmp_mode) && $past(pin_act) == IO_11
      |-> s_q.pin != $past(s_q.pin))
    else $error("pin did not toggle on compare A match");

  a_cmp_nochange: assert property (
      compare_a_flag && $past(cmp_mode) && $past(pin_act) == IO_00
      |-> s_q.pin == $past(s_q.pin))
    else $error("pin moved with pin action zero");

  a_same_level: assert property (
      compare_a_flag && $past(cmp_mode) && $past(pin_act) == IO_10 &&
      $past(s_q.pin) |-> $stable(s_q.pin))
    else $error("pin changed though level already set");

  // pwm mode: forced levels and the waveform against the duty value
  a_pwm_inactive: assert property (
      $past(pwm_mode && run && !run_rise) && $past(pin_act) == IO_00
      |-> s_q.pin == !$past(oc))
    else $error("pwm pin not at inactive level");

  a_pwm_active: assert property (
      $past(pwm_mode && run && !run_rise) && $past(pin_act) == IO_01
      |-> s_q.pin == $past(oc))
    else $error("pwm pin not at active level");

  a_pwm_wave: assert property (
      $past(pwm_mode && run && !run_rise && !s_q.mode_output_control[MOC_DPX_BIT]) &&
      $past(pin_act) == IO_10
      |-> s_q.pin == ($past(s_q.count < s_q.compare_a_value) ? $past(oc) : !$past(oc)))
    else $error("pwm waveform level wrong");

  a_pwm_start: assert property (
      run_rise && pwm_mode |=> s_q.pin == $past(oc))
    else $error("pwm pin not at initial level after run rise");

  // invert applies outside timer mode only
  a_out_polarity: assert property (
      timer_output_pin == (s_q.pin ^ ($past(s_q.mode_output_control[MOC_POL_BIT]) &&
      !$past(timer_mode))))
    else $error("output polarity wrong");

  // counter steps by one on a tick unless a selected match clears it
  a_count_step: assert property (
      $past(step && !(clear_on_a ? a_match : period_match))
      |-> s_q.count == $past(s_q.count) + 10'h001)
    else $error("counter did not step on a tick");

  a_count_idle: assert property (
      !$past(tick) && !$past(run_rise) |-> $stable(s_q.count))
    else $error("counter moved without a tick");

  a_a_clears: assert property (
      compare_a_flag && $past(clear_on_a) |-> s_q.count == 10'h000)
    else $error("compare A match did not clear counter");

  a_overflow_wrap: assert property (
      $past(step && overflow) |-> s_q.count == 10'h000)
    else $error("counter did not wrap at maximum");

  a_both_flags: assert property (
      $past(cmp_mode && step && !clr_bit && period_match) |-> period_compare_flag)
    else $error("period flag missing in compare mode");

  a_a_flag_set: assert property (
      $past(step && a_match) |-> compare_a_flag)
    else $error("compare A flag missing on match");

  a_a_flag_match: assert property (
      compare_a_flag |-> $past(s_q.count) + 10'h001 == $past(s_q.compare_a_value))
    else $error("compare A flag without equal count");

  // register bus: high byte read snapshots the low byte, high byte write loads the compare A pair
  a_count_read: assert property (
      !s_q.waitrequest && $past(s_q.waitrequest && bus_req.read &&
      bus_req.address == REG_COUNT_HIGH_BYTE)
      |-> bus_rsp.readdata == {30'h00000000, $past(s_q.count[9:8])})
    else $error("count high byte read wrong");

  a_count_snap: assert property (
      !s_q.waitrequest && $past(s_q.waitrequest && bus_req.read &&
      bus_req.address == REG_COUNT_HIGH_BYTE) |-> s_q.count_buf == $past(s_q.count[7:0]))
    else $error("count low byte not snapshot");

  a_cmpa_load: assert property (
      !s_q.waitrequest && $past(s_q.waitrequest && bus_req.write &&
      bus_req.byteenable[0] && bus_req.address == REG_COMPARE_A_HIGH_BYTE)
      |-> s_q.compare_a_value == {$past(bus_req.writedata[1:0]), $past(s_q.compare_a_buf)})
    else $error("compare A pair not loaded");

  c_period_flag: cover property (period_compare_flag && cmp_mode);
  c_a_toggle:    cover property (compare_a_flag && cmp_mode ##1 $changed(timer_output_pin));
  c_pwm_edge:    cover property (pwm_mode && run ##1 $fell(timer_output_pin));
  c_pwm_swap:    cover property (pwm_mode && run && clear_on_a && compare_a_flag);
  c_ext_count:   cover property (tick && s_q.run_clock_control[RCC_CKS_MSB:RCC_CKS_LSB] ==
                                 CKS_EXT_FALL && run);

endmodule : cptm_top

// [sim/cptm_partner.sv]
`timescale 1ns/1ps

// far side: drives the external count line and the sub clock, watches both output pins
module cptm_partner (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic timer_output_pin,
  input  wire logic timer_output_inverted_pin,
  output logic      external_count_input,
  output logic      sub_clock,
  output int        pin_faults
);
  // count lines rest low outside bursts
  initial begin
    external_count_input = 1'b0;
    sub_clock = 1'b0;
    pin_faults = 0;
  end

  // pins checked mid-cycle, where both have settled
  always @(negedge core_clk) begin
    if (!reset && timer_output_inverted_pin !== ~timer_output_pin) begin
      pin_faults = pin_faults + 1;
    end
  end

  // slow pulses, two cycles per level, so a synchronous edge detector sees every one
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge core_clk);
      external_count_input <= 1'b1;
      sub_clock <= 1'b1;
      repeat (2) @(posedge core_clk);
      external_count_input <= 1'b0;
      sub_clock <= 1'b0;
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
  endtask : pulse
endmodule : cptm_partner

// [sim/testbench.sv]
`timescale 1ns/1ps

module testbench
  import cptm_pkg::*;
;
  typedef struct {
    logic [7:0] moc;
    logic [7:0] rcc;
    logic [9:0] a;
    int         win, na, np, nh, pin;
  } cptm_row_s;

  logic          core_clk;
  logic          reset;
  cptm_bus_req_s bus_req;
  cptm_bus_rsp_s bus_rsp;
  logic          ext_in, sub_clk, pin, pin_n, flag_a, flag_p;
  logic [7:0]    q;
  logic [3:0]    be = 4'hf;
  int            mismatches, comparisons, pin_faults, na, np, nh;
  // mode, run/clock, compare a, window, expected a flags, period flags, high cycles, end pin
  cptm_row_s rows[16] = '{
    '{8'h20, 8'h19, 10'h040, 1024, 8, 8, -1, 1},
    '{8'h20, 8'h18, 10'h040, 2048, 2, 2, -1, 1},
    '{8'h39, 8'h19, 10'h020, 256, 8, 0, 128, 1},
    '{8'h09, 8'h19, 10'h020, 256, 8, 0, 256, 1},
    '{8'h19, 8'h19, 10'h020, 256, 8, 0, -1, 0},
    '{8'h29, 8'h19, 10'h020, 256, 8, 0, 256, 1},
    '{8'h39, 8'h19, 10'h000, 1024, 0, 0, 1024, 1},
    '{8'ha8, 8'h19, 10'h020, 256, 2, 2, 64, -1},
    '{8'hac, 8'h19, 10'h020, 256, -1, -1, 192, -1},
    '{8'haa, 8'h19, 10'h040, 256, -1, -1, 256, -1},
    '{8'h88, 8'h19, 10'h020, 256, -1, -1, 0, -1},
    '{8'h98, 8'h19, 10'h020, 256, -1, -1, 256, -1},
    '{8'hc0, 8'h19, 10'h020, 1024, 8, 8, -1, -1},
    '{8'hc0, 8'h09, 10'h020, 1024, 2, 2, -1, -1},
    '{8'hc0, 8'h29, 10'h020, 4096, 2, 2, -1, -1},
    '{8'hc0, 8'h39, 10'h020, 16384, 2, 2, -1, -1}};

  cptm_top u_cptm_top (
    .core_clk(core_clk), .reset(reset), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .external_count_input(ext_in), .sub_clock(sub_clk), .timer_output_pin(pin),
    .timer_output_inverted_pin(pin_n), .compare_a_flag(flag_a), .period_compare_flag(flag_p));

  cptm_partner u_cptm_partner (
    .core_clk(core_clk), .reset(reset), .timer_output_pin(pin),
    .timer_output_inverted_pin(pin_n), .external_count_input(ext_in), .sub_clock(sub_clk),
    .pin_faults(pin_faults));

  // 10 mhz core clock
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // one avalon transfer; request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [4:0] addr, input logic [7:0] data,
                     output logic [7:0] rd);
    int n;
    @(posedge core_clk);
    bus_req <= '{address: addr, read: ~wr, write: wr, writedata: {{3{data}}, data},
                 byteenable: be};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (bus_rsp.waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      mismatches++;
      end_of_test();
    end
    // same edge that saw waitrequest low
    rd = bus_rsp.readdata[7:0];
    bus_req <= '0;
  endtask : bus

  // high byte first, so the low byte comes from the snapshot
  task automatic chk_count(input logic [9:0] exp);
    logic [7:0] hi;
    bus(1'b0, REG_COUNT_HIGH_BYTE, 8'h00, hi);
    bus(1'b0, REG_COUNT_LOW_BYTE, 8'h00, q);
    check({hi, q}, {6'h00, exp});
  endtask : chk_count

  // flags and pin level counted mid-cycle over a whole number of periods
  task automatic window(input int cycles, output int ca, output int cp, output int ch);
    ca = 0;
    cp = 0;
    ch = 0;
    repeat (cycles) begin
      @(negedge core_clk);
      ca += (flag_a === 1'b1);
      cp += (flag_p === 1'b1);
      ch += (pin === 1'b1);
    end
  endtask : window

  // watchdog, well beyond the roughly 30000 cycles the tests need
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end

  // main sequence
  initial begin
    bus_req = '0;
    reset = 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      bus(1'b0, 5'(k * 4), 8'h00, q);
      check(q, 8'h00);
    end
    bus(1'b1, REG_MODE_OUTPUT_CONTROL, 8'ha5, q);
    bus(1'b0, REG_MODE_OUTPUT_CONTROL, 8'h00, q);
    check(q, 8'ha5);
    be = 4'he;
    bus(1'b1, REG_MODE_OUTPUT_CONTROL, 8'h3c, q);
    be = 4'hf;
    bus(1'b0, REG_MODE_OUTPUT_CONTROL, 8'h00, q);
    check(q, 8'ha5);
    bus(1'b1, REG_RUN_CLOCK_CONTROL, 8'hb7, q);
    bus(1'b0, REG_RUN_CLOCK_CONTROL, 8'h00, q);
    check(q, 8'hb7);
    bus(1'b1, REG_COMPARE_A_LOW_BYTE, 8'h5a, q);
    bus(1'b1, REG_COMPARE_A_HIGH_BYTE, 8'hff, q);
    bus(1'b0, REG_COMPARE_A_HIGH_BYTE, 8'h00, q);
    check(q, 8'h03);
    bus(1'b0, REG_COMPARE_A_LOW_BYTE, 8'h00, q);
    check(q, 8'h5a);
    bus(1'b1, REG_COUNT_LOW_BYTE, 8'h77, q);
    chk_count(10'h000);
    foreach (rows[i]) begin
      bus(1'b1, REG_RUN_CLOCK_CONTROL, 8'h00, q);
      bus(1'b1, REG_MODE_OUTPUT_CONTROL, rows[i].moc, q);
      bus(1'b1, REG_COMPARE_A_LOW_BYTE, rows[i].a[7:0], q);
      bus(1'b1, REG_COMPARE_A_HIGH_BYTE, {6'h00, rows[i].a[9:8]}, q);
      bus(1'b1, REG_RUN_CLOCK_CONTROL, rows[i].rcc, q);
      repeat (4) @(posedge core_clk);
      window(rows[i].win, na, np, nh);
      if (rows[i].na >= 0) check(na, rows[i].na);
      if (rows[i].np >= 0) check(np, rows[i].np);
      if (rows[i].nh >= 0) check(nh, rows[i].nh);
      if (rows[i].pin >= 0) check({31'h0, pin}, rows[i].pin);
    end
    // event counting on the external and sub clock lines
    bus(1'b1, REG_RUN_CLOCK_CONTROL, 8'h00, q);
    bus(1'b1, REG_RUN_CLOCK_CONTROL, 8'h68, q);
    u_cptm_partner.pulse(5);
    chk_count(10'd5);
    bus(1'b1, REG_RUN_CLOCK_CONTROL, 8'h70, q);
    bus(1'b1, REG_RUN_CLOCK_CONTROL, 8'h78, q);
    u_cptm_partner.pulse(3);
    chk_count(10'd3);
    bus(1'b1, REG_RUN_CLOCK_CONTROL, 8'hf8, q);
    u_cptm_partner.pulse(4);
    chk_count(10'd3);
    bus(1'b1, REG_RUN_CLOCK_CONTROL, 8'h78, q);
    u_cptm_partner.pulse(2);
    chk_count(10'd5);
    bus(1'b1, REG_RUN_CLOCK_CONTROL, 8'h70, q);
    u_cptm_partner.pulse(2);
    chk_count(10'd5);
    for (int k = 4; k < 6; k++) begin
      bus(1'b1, REG_RUN_CLOCK_CONTROL, 8'h00, q);
      bus(1'b1, REG_RUN_CLOCK_CONTROL, {1'b0, 3'(k), 4'h8}, q);
      u_cptm_partner.pulse(3);
      chk_count(10'd3);
    end
    check(pin_faults, 0);
    end_of_test();
  end
endmodule : testbench
